/* verilog/sysck_pkg.sv */
// constants and types of the system clock mode controller
// assumes a single core clock; all offsets are byte addresses on axi4-lite
package sysck_pkg;
    localparam int SYSCK_ADDR_W = 5;
    localparam logic [4:0] SYSCK_OFS_MODE = 5'h00;
    localparam logic [4:0] SYSCK_OFS_MODE1 = 5'h04;
    localparam logic [4:0] SYSCK_OFS_STAT = 5'h08;
    localparam logic [4:0] SYSCK_OFS_MASK = 5'h0c;
    localparam int SYSCK_HCLK_BIT = 0;
    localparam int SYSCK_IDLE_BIT = 1;
    localparam int SYSCK_HRDY_BIT = 2;
    localparam int SYSCK_LRDY_BIT = 3;
    localparam int SYSCK_FAST_BIT = 4;
    localparam int SYSCK_DIV_LSB = 5;
    localparam int SYSCK_KEEP_BIT = 0;
    localparam logic [7:0] SYSCK_MODE_RST = 8'h03;
    localparam logic [7:0] SYSCK_MODE_RO = 8'h0c;
    localparam logic [0:0] SYSCK_MODE1_RST = 1'h0;
    localparam logic [2:0] SYSCK_MASK_RST = 3'h0;
    localparam int SYSCK_EV_HRDY = 0;
    localparam int SYSCK_EV_LRDY = 1;
    localparam int SYSCK_EV_WAKE = 2;
    localparam int SYSCK_STAB_W = 11;
    localparam logic [10:0] SYSCK_HXT_STAB = 11'h400;
    localparam logic [10:0] SYSCK_HRC_STAB = 11'h010;
    localparam logic [10:0] SYSCK_LXT_STAB = 11'h400;
    localparam logic [10:0] SYSCK_INTERNAL_LOW_RC_STAB = 11'h002;
    localparam logic [2:0] SYSCK_DIV_FIRST_HIGH = 3'h2;
    localparam logic [1:0] SYSCK_RESP_OKAY = 2'h0;
    localparam logic [1:0] SYSCK_RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        SYSCK_HOSC_CRYSTAL = 2'b00,
        SYSCK_HOSC_EXT_RC = 2'b01,
        SYSCK_HOSC_INT_RC = 2'b10
    } sysck_hosc_t;

    typedef enum logic [2:0] {
        SYSCK_ST_RUN = 3'b000,
        SYSCK_ST_IDLE_RUN = 3'b001,
        SYSCK_ST_IDLE_STOP = 3'b010,
        SYSCK_ST_SLEEP = 3'b011,
        SYSCK_ST_DEEP_SLEEP = 3'b100
    } sysck_state_t;
endpackage : sysck_pkg

/* verilog/sysck_stab_if.sv */
// links one oscillator stabilisation counter to the controller
// assumes the controller drives enable, tick and target
`timescale 1ns/100ps
interface sysck_stab_if #(parameter int W = 11);
    logic enable;
    logic tick;
    logic [W-1:0] target;
    logic ready;
    modport ctr (input enable, input tick, input target, output ready);
    modport user (output enable, output tick, output target, input ready);
endinterface : sysck_stab_if

/* verilog/sysck_stab.sv */
// counts oscillator ticks after enable until the oscillator is stable
// assumes tick is a one-cycle enable synchronous to clk
`timescale 1ns/100ps
module sysck_stab #(
    parameter int W = 11
) (
    input wire logic clk,
    input wire logic rst_n,
    sysck_stab_if.ctr stab
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic ready_reg;
    logic ready_next;

    always_comb begin
        count_next = count_reg;
        ready_next = ready_reg;
        // oscillator stopped: stability is lost at once
        if (!stab.enable) begin
            count_next = '0;
            ready_next = 1'b0;
        end else if (stab.tick && !ready_reg) begin
            count_next = count_reg + 1'b1;
            ready_next = (count_next == stab.target);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            ready_reg <= ready_next;
        end
    end

    assign stab.ready = ready_reg;
endmodule : sysck_stab

/* verilog/sysck_ctrl.sv */
// system clock mode controller: mode register, clock select, halt modes
// assumes oscillator ticks and strobes are synchronous to CORE_CLK
//
// Overview of operation
// - divide codes: low clock, or high/64 to /2
// - high select bit picks undivided high clock
// - high oscillator stops when low clock used
// - fast wake runs on substitute low clock
// - low ready clear in deep sleep, then counts
// - high ready cleared at power-on, set stable
// - high ready clear asleep; 1024 or 16 cycles
// - halt enters idle or sleep by bit
// - idle keeps or stops system clock by bit
// - substitute clock until crystal ready, then switch
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module sysck_ctrl (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [4:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [4:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic HOSC_TICK,
    input wire logic LOSC_TICK,
    input wire logic [1:0] HOSC_TYPE,
    input wire logic LOSC_IS_CRYSTAL,
    input wire logic WDT_LVD_ON,
    input wire logic HALT_REQ,
    input wire logic WAKE_REQ,
    output logic SYS_CLK_EN,
    output logic CPU_RUN,
    output logic HIGH_OSC_EN,
    output logic LOW_OSC_EN,
    output logic SUB_CLK_ACTIVE,
    output logic IRQ
);
    sysck_stab_if #(.W(sysck_pkg::SYSCK_STAB_W)) hstab ();
    sysck_stab_if #(.W(sysck_pkg::SYSCK_STAB_W)) lstab ();

    sysck_stab #(.W(sysck_pkg::SYSCK_STAB_W)) u_hstab (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .stab(hstab)
    );
    sysck_stab #(.W(sysck_pkg::SYSCK_STAB_W)) u_lstab (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .stab(lstab)
    );

    sysck_pkg::sysck_state_t state_reg, state_next;
    logic [7:0] mode_reg, mode_next;
    logic keep_reg, keep_next;
    logic [2:0] stat_reg, stat_next;
    logic [2:0] mask_reg, mask_next;
    logic fast_reg, fast_next;
    logic [5:0] divcnt_reg, divcnt_next;
    logic hrdy_d_reg, lrdy_d_reg;
    logic sysen_reg, sysen_next;
    logic hen_reg, hen_next;
    logic len_reg, len_next;
    logic irq_reg;
    logic cpu_run_reg;
    logic aw_hold_reg, aw_hold_next;
    logic [4:0] aw_addr_reg, aw_addr_next;
    logic w_hold_reg, w_hold_next;
    logic [31:0] w_data_reg, w_data_next;
    logic w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    logic hrdy, lrdy, hclk, idle_en, fast_en, high_needed, clk_on;
    logic div_tick, high_sel, aw_take, w_take, do_wr, ar_take;
    logic [2:0] div;
    logic [5:0] div_mask;
    logic [4:0] wa;
    logic [31:0] wd;
    logic [7:0] mode_rd;
    logic [2:0] events;

    assign hrdy = hstab.ready;
    assign lrdy = lstab.ready;
    assign hclk = mode_reg[sysck_pkg::SYSCK_HCLK_BIT];
    assign idle_en = mode_reg[sysck_pkg::SYSCK_IDLE_BIT];
    assign fast_en = mode_reg[sysck_pkg::SYSCK_FAST_BIT];
    assign div = mode_reg[sysck_pkg::SYSCK_DIV_LSB +: 3];
    assign high_needed = hclk || (div >= sysck_pkg::SYSCK_DIV_FIRST_HIGH);
    assign clk_on = (state_reg == sysck_pkg::SYSCK_ST_RUN)
        || (state_reg == sysck_pkg::SYSCK_ST_IDLE_RUN);
    // ready flags live in the counters, merged in on read
    assign mode_rd = mode_reg
        | ({7'h00, lrdy} << sysck_pkg::SYSCK_LRDY_BIT)
        | ({7'h00, hrdy} << sysck_pkg::SYSCK_HRDY_BIT);

    always_comb begin
        case (div)
            3'h2: div_mask = 6'h3f;
            3'h3: div_mask = 6'h1f;
            3'h4: div_mask = 6'h0f;
            3'h5: div_mask = 6'h07;
            3'h6: div_mask = 6'h03;
            3'h7: div_mask = 6'h01;
            default: div_mask = 6'h00;
        endcase
    end
    assign div_tick = HOSC_TICK && ((divcnt_reg & div_mask) == div_mask);
    assign high_sel = hclk ? HOSC_TICK : div_tick;

    // oscillator stabilisation counters
    always_comb begin
        hstab.enable = clk_on && high_needed;
        hstab.tick = HOSC_TICK;
        hstab.target = (HOSC_TYPE == sysck_pkg::SYSCK_HOSC_CRYSTAL)
            ? sysck_pkg::SYSCK_HXT_STAB : sysck_pkg::SYSCK_HRC_STAB;
        lstab.enable = (state_reg != sysck_pkg::SYSCK_ST_DEEP_SLEEP);
        lstab.tick = LOSC_TICK;
        lstab.target = LOSC_IS_CRYSTAL
            ? sysck_pkg::SYSCK_LXT_STAB : sysck_pkg::SYSCK_INTERNAL_LOW_RC_STAB;
    end

    // mode machine, clock selection and events
    always_comb begin
        state_next = state_reg;
        fast_next = fast_reg && !hrdy;
        divcnt_next = HOSC_TICK ? divcnt_reg + 6'h01 : divcnt_reg;
        events = 3'h0;
        events[sysck_pkg::SYSCK_EV_HRDY] = hrdy && !hrdy_d_reg;
        events[sysck_pkg::SYSCK_EV_LRDY] = lrdy && !lrdy_d_reg;
        case (state_reg)
            sysck_pkg::SYSCK_ST_RUN: begin
                if (HALT_REQ) begin
                    if (idle_en) begin
                        state_next = keep_reg
                            ? sysck_pkg::SYSCK_ST_IDLE_RUN
                            : sysck_pkg::SYSCK_ST_IDLE_STOP;
                    end else begin
                        // no watchdog or lvd: substitute clock stops too
                        state_next = WDT_LVD_ON
                            ? sysck_pkg::SYSCK_ST_SLEEP
                            : sysck_pkg::SYSCK_ST_DEEP_SLEEP;
                    end
                end
            end
            sysck_pkg::SYSCK_ST_IDLE_RUN,
            sysck_pkg::SYSCK_ST_IDLE_STOP,
            sysck_pkg::SYSCK_ST_SLEEP,
            sysck_pkg::SYSCK_ST_DEEP_SLEEP: begin
                if (WAKE_REQ) begin
                    state_next = sysck_pkg::SYSCK_ST_RUN;
                    events[sysck_pkg::SYSCK_EV_WAKE] = 1'b1;
                    // substitute clock only exists where it kept running
                    fast_next = fast_en && high_needed
                        && (HOSC_TYPE == sysck_pkg::SYSCK_HOSC_CRYSTAL)
                        && ((state_reg == sysck_pkg::SYSCK_ST_SLEEP)
                        || (state_reg == sysck_pkg::SYSCK_ST_IDLE_STOP));
                end
            end
            default: state_next = sysck_pkg::SYSCK_ST_RUN;
        endcase
        if (!clk_on) begin
            sysen_next = 1'b0;
        end else if (fast_reg && !hrdy) begin
            sysen_next = LOSC_TICK;
        end else if (high_needed) begin
            sysen_next = hrdy && high_sel;
        end else begin
            sysen_next = lrdy && LOSC_TICK;
        end
        hen_next = hstab.enable;
        len_next = lstab.enable;
    end

    // axi4-lite slave: address and data taken in either order
    assign aw_take = S_AXI_AWVALID && awready_reg;
    assign w_take = S_AXI_WVALID && wready_reg;
    assign wa = aw_hold_reg ? aw_addr_reg : S_AXI_AWADDR;
    assign wd = w_hold_reg ? w_data_reg : S_AXI_WDATA;
    assign do_wr = (aw_hold_reg || aw_take) && (w_hold_reg || w_take)
        && !bvalid_reg;
    assign ar_take = S_AXI_ARVALID && arready_reg;

    always_comb begin
        aw_hold_next = aw_hold_reg || aw_take;
        aw_addr_next = aw_take ? S_AXI_AWADDR : aw_addr_reg;
        w_hold_next = w_hold_reg || w_take;
        w_data_next = w_take ? S_AXI_WDATA : w_data_reg;
        w_strb_next = w_take ? S_AXI_WSTRB[0] : w_strb_reg;
        bvalid_next = bvalid_reg && !S_AXI_BREADY;
        bresp_next = bresp_reg;
        mode_next = mode_reg;
        keep_next = keep_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        if (do_wr) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = sysck_pkg::SYSCK_RESP_OKAY;
            if (w_take ? S_AXI_WSTRB[0] : w_strb_reg) begin
                case (wa)
                    sysck_pkg::SYSCK_OFS_MODE:
                        mode_next = wd[7:0] & ~sysck_pkg::SYSCK_MODE_RO;
                    sysck_pkg::SYSCK_OFS_MODE1:
                        keep_next = wd[sysck_pkg::SYSCK_KEEP_BIT];
                    sysck_pkg::SYSCK_OFS_STAT:
                        stat_next = stat_reg & ~wd[2:0];
                    sysck_pkg::SYSCK_OFS_MASK: mask_next = wd[2:0];
                    default: bresp_next = sysck_pkg::SYSCK_RESP_DECERR;
                endcase
            end
            if (wa > sysck_pkg::SYSCK_OFS_MASK || wa[1:0] != 2'h0) begin
                bresp_next = sysck_pkg::SYSCK_RESP_DECERR;
            end
        end
        // a new event beats a clear in the same cycle
        stat_next = stat_next | events;
        awready_next = !aw_hold_next && !bvalid_next;
        wready_next = !w_hold_next && !bvalid_next;
        rvalid_next = rvalid_reg && !S_AXI_RREADY;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (ar_take) begin
            rvalid_next = 1'b1;
            rresp_next = sysck_pkg::SYSCK_RESP_OKAY;
            case (S_AXI_ARADDR)
                sysck_pkg::SYSCK_OFS_MODE: rdata_next = {24'h000000, mode_rd};
                sysck_pkg::SYSCK_OFS_MODE1: rdata_next = {31'h0, keep_reg};
                sysck_pkg::SYSCK_OFS_STAT: rdata_next = {29'h0, stat_reg};
                sysck_pkg::SYSCK_OFS_MASK: rdata_next = {29'h0, mask_reg};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = sysck_pkg::SYSCK_RESP_DECERR;
                end
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= sysck_pkg::SYSCK_ST_RUN;
            mode_reg <= sysck_pkg::SYSCK_MODE_RST;
            keep_reg <= sysck_pkg::SYSCK_MODE1_RST;
            stat_reg <= 3'h0;
            mask_reg <= sysck_pkg::SYSCK_MASK_RST;
            fast_reg <= 1'b0;
            divcnt_reg <= 6'h00;
            hrdy_d_reg <= 1'b0;
            lrdy_d_reg <= 1'b0;
            sysen_reg <= 1'b0;
            hen_reg <= 1'b0;
            len_reg <= 1'b0;
            irq_reg <= 1'b0;
            cpu_run_reg <= 1'b1;
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            keep_reg <= keep_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            fast_reg <= fast_next;
            divcnt_reg <= divcnt_next;
            hrdy_d_reg <= hrdy;
            lrdy_d_reg <= lrdy;
            sysen_reg <= sysen_next;
            hen_reg <= hen_next;
            len_reg <= len_next;
            irq_reg <= |(stat_next & mask_next);
            // registered copy of the run decode, same edge as the state
            cpu_run_reg <= (state_next == sysck_pkg::SYSCK_ST_RUN);
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign SYS_CLK_EN = sysen_reg;
    assign CPU_RUN = cpu_run_reg;
    assign HIGH_OSC_EN = hen_reg;
    assign LOW_OSC_EN = len_reg;
    assign SUB_CLK_ACTIVE = fast_reg;
    assign IRQ = irq_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_div_slow_src: assert property (
        (clk_on && !fast_reg && !high_needed && lrdy && LOSC_TICK)
        |=> SYS_CLK_EN)
        else $error("low clock tick not passed to system clock");
    a_div_by_two: assert property (
        (clk_on && !fast_reg && !hclk && div == 3'h7 && hrdy
        && HOSC_TICK && divcnt_reg[0] == 1'b0) |=> !SYS_CLK_EN)
        else $error("divide by two passed an even tick");
    a_full_high: assert property (
        (clk_on && hclk && !fast_reg && hrdy && HOSC_TICK) |=> SYS_CLK_EN)
        else $error("undivided high clock tick lost");
    a_high_stop_slow: assert property (
        (!high_needed && $stable(mode_reg)) |=> !HIGH_OSC_EN)
        else $error("high oscillator runs on low clock");
    a_fast_sub_clk: assert property (
        (state_reg == sysck_pkg::SYSCK_ST_RUN && fast_reg && !hrdy)
        |=> (SYS_CLK_EN == $past(LOSC_TICK)))
        else $error("fast wake not on substitute clock");
    a_low_deep_clear: assert property (
        (state_reg == sysck_pkg::SYSCK_ST_DEEP_SLEEP)
        ##1 (state_reg == sysck_pkg::SYSCK_ST_DEEP_SLEEP) |-> !lrdy)
        else $error("low ready set in deep sleep");
    a_high_sleep_clear: assert property (
        (!clk_on ##1 !clk_on) |-> !hrdy)
        else $error("high ready set while clock stopped");
    a_fast_ends: assert property (
        (fast_reg && hrdy) |=> !SUB_CLK_ACTIVE)
        else $error("substitute clock kept after high ready");
    a_halt_idle: assert property (
        (CPU_RUN && HALT_REQ && idle_en) |=> (state_reg
        inside {sysck_pkg::SYSCK_ST_IDLE_RUN, sysck_pkg::SYSCK_ST_IDLE_STOP}))
        else $error("halt with idle bit did not enter idle");
    a_halt_sleep: assert property (
        (CPU_RUN && HALT_REQ && !idle_en) |=> (state_reg
        inside {sysck_pkg::SYSCK_ST_SLEEP, sysck_pkg::SYSCK_ST_DEEP_SLEEP}))
        else $error("halt without idle bit did not sleep");
    a_idle_stop_clk: assert property (
        (state_reg == sysck_pkg::SYSCK_ST_IDLE_STOP) |=> !SYS_CLK_EN)
        else $error("system clock runs in stopped idle");
    a_ro_flags: assert property (
        (mode_reg & sysck_pkg::SYSCK_MODE_RO) == 8'h00)
        else $error("ready flag bits stored from software");

    c_fast_wake: cover property ($rose(fast_reg) ##[1:1000] $fell(fast_reg));
    c_deep_sleep: cover property (state_reg
        == sysck_pkg::SYSCK_ST_DEEP_SLEEP ##1 CPU_RUN);
    c_idle_run: cover property (state_reg == sysck_pkg::SYSCK_ST_IDLE_RUN
        && SYS_CLK_EN);
    c_irq: cover property ($rose(IRQ));
endmodule : sysck_ctrl

/* testbench/system_clock_mode_control_test.sv */
// self-checking bench for the system clock mode controller
// assumes sysck_pkg, sysck_stab_if, sysck_stab and sysck_ctrl compiled first
`timescale 1ns/100ps
module system_clock_mode_control_test;
    localparam int LIMIT = 20000;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic hosc_tick = 1'b0, losc_tick = 1'b0;
    logic [1:0] hosc_type = 2'h2;
    logic wdt_lvd_on = 1'b0, halt_req = 1'b0, wake_req = 1'b0;
    logic losc_xtal = 1'b0;
    logic sys_clk_en, cpu_run, high_osc_en, low_osc_en, sub_clk_active, irq;
    logic [1:0] lphase = 2'h0;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int ticks;

    sysck_ctrl dut (.CORE_CLK(core_clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .HOSC_TICK(hosc_tick), .LOSC_TICK(losc_tick),
        .HOSC_TYPE(hosc_type), .LOSC_IS_CRYSTAL(losc_xtal),
        .WDT_LVD_ON(wdt_lvd_on), .HALT_REQ(halt_req), .WAKE_REQ(wake_req),
        .SYS_CLK_EN(sys_clk_en), .CPU_RUN(cpu_run),
        .HIGH_OSC_EN(high_osc_en), .LOW_OSC_EN(low_osc_en),
        .SUB_CLK_ACTIVE(sub_clk_active), .IRQ(irq));

    always #50 core_clk = ~core_clk;

    // oscillators tick only while enabled, so a stopped source stays silent
    always @(posedge core_clk) begin
        lphase <= lphase + 2'h1;
        hosc_tick <= high_osc_en;
        losc_tick <= low_osc_en & (lphase == 2'h3);
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // bready and rready stay up after the first transfer, so back to back
    // calls never drive them twice in one step; a wait ends on bvalid or rvalid, else at the LIMIT timeout
    task automatic axi_wr(input logic [4:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [4:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
    endtask : axi_rd

    task automatic count_ticks(input int win);
        ticks = 0;
        repeat (win) begin
            @(posedge core_clk);
            if (sys_clk_en === 1'b1) ticks++;
        end
    endtask : count_ticks

    task automatic strobe(input logic wake);
        halt_req <= ~wake;
        wake_req <= wake;
        @(posedge core_clk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : strobe

    task automatic t_reset_ro;
        axi_rd(5'h00);
        chk("mode after reset", 32'h03, rd);
        chk("read resp okay", 32'h0, {30'h0, resp});
        repeat (40) @(posedge core_clk);
        axi_rd(5'h00);
        chk("mode stable", 32'h0f, rd);
        axi_wr(5'h00, 8'h00);
        chk("write resp okay", 32'h0, {30'h0, resp});
        repeat (40) @(posedge core_clk);
        chk("high osc stop", 32'h0, {31'h0, high_osc_en});
        axi_rd(5'h00);
        chk("ready read only", 32'h08, rd);
        axi_wr(5'h00, 8'h0f);
        axi_rd(5'h00);
        chk("ready not set", 32'h0b, rd);
        repeat (40) @(posedge core_clk);
    endtask : t_reset_ro

    task automatic t_divide;
        for (int c = 0; c < 9; c++) begin
            // code 8 stands for the undivided high select
            axi_wr(5'h00, (c == 8) ? 8'h03 : {c[2:0], 5'h02});
            repeat (60) @(posedge core_clk);
            count_ticks(128);
            chk("tick count", (c < 2) ? 32 : (1 << (c - 1)), ticks);
            chk("high osc en", (c >= 2), {31'h0, high_osc_en});
        end
    endtask : t_divide

    task automatic t_halt;
        axi_wr(5'h08, 8'h07);
        axi_wr(5'h04, 8'h00);
        strobe(1'b0);
        chk("cpu stopped", 32'h0, {31'h0, cpu_run});
        count_ticks(20);
        chk("idle stopped ticks", 32'h0, ticks);
        axi_rd(5'h00);
        chk("high ready idle", 32'h0b, rd);
        strobe(1'b1);
        repeat (40) @(posedge core_clk);
        chk("cpu running", 32'h1, {31'h0, cpu_run});
        axi_rd(5'h08);
        chk("status wake", 32'h05, rd);
        chk("irq masked", 32'h0, {31'h0, irq});
        axi_wr(5'h0c, 8'h04);
        chk("irq raised", 32'h1, {31'h0, irq});
        axi_wr(5'h08, 8'h04);
        chk("irq cleared", 32'h0, {31'h0, irq});
        axi_wr(5'h04, 8'h01);
        strobe(1'b0);
        count_ticks(32);
        chk("idle running ticks", 32'd32, ticks);
        strobe(1'b1);
        axi_wr(5'h00, 8'h01);
        strobe(1'b0);
        chk("low osc off", 32'h0, {31'h0, low_osc_en});
        axi_rd(5'h00);
        chk("deep sleep ready", 32'h01, rd);
        strobe(1'b1);
        repeat (40) @(posedge core_clk);
        axi_rd(5'h00);
        chk("ready after wake", 32'h0d, rd);
    endtask : t_halt

    task automatic t_fast_wake;
        wdt_lvd_on <= 1'b1;
        axi_wr(5'h00, 8'h11);
        strobe(1'b0);
        hosc_type <= 2'h0;
        strobe(1'b1);
        chk("substitute on", 32'h1, {31'h0, sub_clk_active});
        count_ticks(1000);
        chk("substitute ticks", 32'd250, ticks);
        chk("substitute held", 32'h1, {31'h0, sub_clk_active});
        repeat (100) @(posedge core_clk);
        chk("substitute off", 32'h0, {31'h0, sub_clk_active});
        axi_rd(5'h00);
        chk("crystal ready", 32'h1d, rd);
    endtask : t_fast_wake

    // low crystal needs 1024 low ticks (4 cycles each) after deep sleep
    task automatic t_low_crystal;
        wdt_lvd_on <= 1'b0;
        losc_xtal <= 1'b1;
        axi_wr(5'h00, 8'h01);
        strobe(1'b0);
        strobe(1'b1);
        repeat (4000) @(posedge core_clk);
        axi_rd(5'h00);
        chk("low crystal wait", 32'h05, rd);
        repeat (100) @(posedge core_clk);
        axi_rd(5'h00);
        chk("low crystal ready", 32'h0d, rd);
    endtask : t_low_crystal

    task automatic t_unmapped;
        axi_rd(5'h10);
        chk("unmapped resp", 32'h3, {30'h0, resp});
        chk("unmapped data", 32'h0, rd);
        axi_wr(5'h02, 8'hff);
        chk("misaligned resp", 32'h3, {30'h0, resp});
    endtask : t_unmapped

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset_ro();
        t_divide();
        t_halt();
        t_unmapped();
        t_fast_wake();
        t_low_crystal();
        stop_test();
    end
endmodule : system_clock_mode_control_test
